// ---- logic/cas_pkg.sv ----
// cas_pkg: shared constants and types for the concentration alarm and span check block
// assumes a 200 MHz clock and a classic wishbone register bus with 32-bit data
package cas_pkg;
  // register byte offsets
  localparam logic [4:0] CAS_ADR_ALM1   = 5'h00;
  localparam logic [4:0] CAS_ADR_ALM2   = 5'h04;
  localparam logic [4:0] CAS_ADR_SPCTL  = 5'h08;
  localparam logic [4:0] CAS_ADR_SPVAL  = 5'h0C;
  localparam logic [4:0] CAS_ADR_STAT   = 5'h10;
  localparam logic [4:0] CAS_ADR_SLOPE  = 5'h14;
  localparam logic [4:0] CAS_ADR_CALSEN = 5'h18;

  // span control field positions (write pulses and stored fields)
  localparam int CAS_SPCTL_AUTO  = 0;
  localparam int CAS_SPCTL_START = 8;
  localparam int CAS_SPCTL_ENTER = 9;
  localparam int CAS_SPCTL_UP    = 10;
  localparam int CAS_SPCTL_DOWN  = 11;
  localparam int CAS_SPCTL_HOLD  = 16;

  // widths of measured quantities
  localparam int CAS_PPM_W  = 18;  // 0..250000 ppm
  localparam int CAS_SPAN_W = 25;  // span value in hundredths of ppm
  localparam int CAS_SENS_W = 16;  // cell sensitivity in nA per ppm

  // reset values and limits
  localparam logic [5:0]           CAS_HOLD_RST  = 6'h05;
  localparam logic [5:0]           CAS_HOLD_MIN  = 6'h01;
  localparam logic [5:0]           CAS_HOLD_MAX  = 6'h3C;
  localparam logic [CAS_SPAN_W-1:0] CAS_SPAN_RST = 25'h0000320;  // 8.00 ppm
  localparam logic [CAS_SENS_W-1:0] CAS_SENS_MIN = 16'h01F4;     // 0.5 uA/ppm = 500 nA/ppm
  localparam logic [CAS_SENS_W-1:0] CAS_SENS_RST = 16'h01F4;
  localparam logic [CAS_PPM_W:0]   CAS_SLOPE_TOL = 19'h00001;    // stable when |slope| <= this

  // times in their own units, then cycle counts
  localparam longint CAS_CLK_HZ      = 200000000;
  localparam longint CAS_SAMPLE_MS   = 1000;
  localparam longint CAS_MINUTE_S    = 60;
  localparam longint CAS_FAILMSG_S   = 5;
  localparam longint CAS_SAMPLE_CYC  = CAS_CLK_HZ * CAS_SAMPLE_MS / 1000;
  localparam longint CAS_MINUTE_CYC  = CAS_CLK_HZ * CAS_MINUTE_S;
  localparam longint CAS_FAILMSG_CYC = CAS_CLK_HZ * CAS_FAILMSG_S;

  // one alarm's configuration as it sits in its register
  typedef struct packed {
    logic                 latching;
    logic                 deenergize_on_trip_setting;
    logic                 defeat;
    logic                 dir_high;
    logic [5:0]           pad;
    logic [CAS_PPM_W-1:0] setpoint;
  } cas_alm_cfg_t;

  localparam cas_alm_cfg_t CAS_ALM_RST = '{latching: 1'b0, deenergize_on_trip_setting: 1'b0,
                                           defeat: 1'b1, dir_high: 1'b1, pad: 6'h00,
                                           setpoint: 18'h003E8};

  // span calibration sequence
  typedef enum logic [1:0] {
    CAS_ANALYZE,
    CAS_SETTLE,
    CAS_HOLD,
    CAS_FAILMSG
  } cas_cal_st_t;
endpackage

// ---- logic/cas_top.sv ----
// cas_top: two concentration alarms with relays, span calibration and calibration fault
// assumes concentration and cell sensitivity arrive synchronous to clk_i; rst_i is the
// power cycle through the standby key, the only thing that clears the calibration fault
//
// Operation
// - two alarms, each with setpoint, direction, defeat, failsafe and latching
// - high alarm trips when concentration rises above setpoint
// - low alarm trips when concentration falls below setpoint
// - failsafe relay de-energized while alarm present, energized otherwise
// - non-failsafe relay energized while alarm present, de-energized otherwise
// - latching alarm holds after concentration recovers until operator resets it
// - non-latching alarm drops as soon as concentration recovers
// - defeat suppresses the alarm entirely
// - defeat toggled yes then no clears a latched alarm
// - latching toggled no then yes clears a latched alarm
// - span rejected, old calibration kept, when sensitivity below 0.5 uA/ppm
// - rejected span raises system alarm, shows failure five seconds, then analyze
// - after rejection fault flag and system alarm stay shown
// - fault and system alarm clear only by power cycle, not good span
// - auto hold time defaults 5 minutes, adjustable 1 to 60 minutes
// - hold time has no effect in manual settling
// - auto span ends alone when output matches span, then analyze; here it ends after the hold time once the slope is stable
// - during span sample at fixed rate, difference of samples is slope
// - manual span: enter sets reading to span value, then analyze
//
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module cas_top
  import cas_pkg::*;
#(
  parameter longint SAMPLE_CYC  = CAS_SAMPLE_CYC,
  parameter longint MINUTE_CYC  = CAS_MINUTE_CYC,
  parameter longint FAILMSG_CYC = CAS_FAILMSG_CYC
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [4:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  // sensor
  input  wire logic [CAS_PPM_W-1:0]  conc_i,
  input  wire logic [CAS_SENS_W-1:0] sens_i,
  // relays and indications
  output logic      [1:0]            relay_o,
  output logic                       sys_alarm_o,
  output logic                       calibration_fault_flag_o,
  output logic                       fail_msg_o,
  output logic                       analyze_o
);

  // bus decode; a request is taken in the cycle where ack is not yet up
  logic take;
  logic wr;
  assign take = cyc_i & stb_i & ~ack_o;
  assign wr   = take & we_i;

  // configuration registers
  cas_alm_cfg_t           alm_cfg_q [2];
  logic                   auto_q;
  logic [5:0]             hold_min_q;
  logic [CAS_SPAN_W-1:0]  span_val_q;

  // alarm configuration, written with byte enables
  always_ff @(posedge clk_i) begin
    for (int a = 0; a < 2; a++) begin
      if (rst_i) begin
        alm_cfg_q[a] <= CAS_ALM_RST;
      end else if (wr && adr_i == (a == 0 ? CAS_ADR_ALM1 : CAS_ADR_ALM2)) begin
        for (int b = 0; b < 4; b++) begin
          if (sel_i[b] && b < 3) begin
            alm_cfg_q[a][b*8 +: 8] <= dat_i[b*8 +: 8];
          end else if (sel_i[b]) begin
            alm_cfg_q[a][27:24] <= dat_i[27:24];
          end
        end
      end
    end
  end

  // span value, kept as hundredths of ppm
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      span_val_q <= CAS_SPAN_RST;
    end else if (wr && adr_i == CAS_ADR_SPVAL && sel_i == 4'hF) begin
      span_val_q <= dat_i[CAS_SPAN_W-1:0];
    end
  end

  // settling mode and hold time; up and down pulses saturate at the limits
  logic spctl_wr;
  assign spctl_wr = wr && adr_i == CAS_ADR_SPCTL && sel_i[1:0] == 2'h3;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_q     <= 1'b1;
      hold_min_q <= CAS_HOLD_RST;
    end else if (spctl_wr) begin
      auto_q <= dat_i[CAS_SPCTL_AUTO];
      if (dat_i[CAS_SPCTL_UP] && hold_min_q < CAS_HOLD_MAX) begin
        hold_min_q <= hold_min_q + 6'h01;
      end else if (dat_i[CAS_SPCTL_DOWN] && hold_min_q > CAS_HOLD_MIN) begin
        hold_min_q <= hold_min_q - 6'h01;
      end
    end
  end

  // alarm conditions and state; previous config kept to see toggle sequences
  logic [1:0]   alm_q;
  logic [1:0]   dft_prev_q;
  logic [1:0]   ltch_prev_q;
  logic [1:0]   cond;
  logic [1:0]   clr_evt;
  always_comb begin
    for (int a = 0; a < 2; a++) begin
      cond[a] = alm_cfg_q[a].dir_high ? (conc_i > alm_cfg_q[a].setpoint)
                                      : (conc_i < alm_cfg_q[a].setpoint);
      clr_evt[a] = (dft_prev_q[a] & ~alm_cfg_q[a].defeat)
                 | (~ltch_prev_q[a] & alm_cfg_q[a].latching);
    end
  end

  always_ff @(posedge clk_i) begin
    for (int a = 0; a < 2; a++) begin
      if (rst_i) begin
        alm_q[a]       <= 1'b0;
        dft_prev_q[a]  <= CAS_ALM_RST.defeat;
        ltch_prev_q[a] <= CAS_ALM_RST.latching;
      end else begin
        dft_prev_q[a]  <= alm_cfg_q[a].defeat;
        ltch_prev_q[a] <= alm_cfg_q[a].latching;
        // defeat wins over all, so maintenance never trips a relay
        if (alm_cfg_q[a].defeat) begin
          alm_q[a] <= 1'b0;
        end else if (alm_cfg_q[a].latching && !clr_evt[a]) begin
          alm_q[a] <= alm_q[a] | cond[a];
        end else begin
          alm_q[a] <= cond[a];  // (a fresh trip beats a clear)
        end
      end
    end
  end

  // relay drive follows alarm state one cycle later
  // reset leaves every relay off, even a failsafe one, until it is configured
  always_ff @(posedge clk_i) begin
    for (int a = 0; a < 2; a++) begin
      if (rst_i) begin
        relay_o[a] <= 1'b0;
      end else if (alm_cfg_q[a].deenergize_on_trip_setting) begin
        relay_o[a] <= ~alm_q[a];
      end else begin
        relay_o[a] <= alm_q[a];
      end
    end
  end

  // span calibration sequence
  cas_cal_st_t             st_q;
  logic [31:0]             samp_cnt_q;
  logic                    samp_tick;
  logic [CAS_PPM_W-1:0]    prev_conc_q;
  logic signed [CAS_PPM_W:0] slope_q;
  logic [35:0]             min_cnt_q;
  logic [5:0]              min_done_q;
  logic [31:0]             msg_cnt_q;
  logic [CAS_SENS_W-1:0]   cal_sens_q;
  logic [CAS_SPAN_W-1:0]   span_rdg_q;
  logic                    fault_q;
  logic                    start_p;
  logic                    enter_p;
  logic                    stable;
  logic                    span_end;

  assign start_p   = spctl_wr & dat_i[CAS_SPCTL_START];
  assign enter_p   = spctl_wr & dat_i[CAS_SPCTL_ENTER];
  assign samp_tick = samp_cnt_q == 32'(SAMPLE_CYC - 1);
  assign stable    = (slope_q >= -$signed(CAS_SLOPE_TOL)) && (slope_q <= $signed(CAS_SLOPE_TOL));
  // auto ends after the hold time once readings still agree; manual ends on enter
  assign span_end  = (st_q == CAS_HOLD && min_done_q >= hold_min_q && stable)
                   | (st_q == CAS_SETTLE && !auto_q && enter_p);

  // fixed-rate sampling and slope; runs only while a span is in progress
  always_ff @(posedge clk_i) begin
    if (rst_i || st_q == CAS_ANALYZE || st_q == CAS_FAILMSG) begin
      samp_cnt_q  <= 32'h00000000;
      prev_conc_q <= conc_i;
      slope_q     <= '0;
    end else if (samp_tick) begin
      samp_cnt_q  <= 32'h00000000;
      prev_conc_q <= conc_i;
      slope_q     <= $signed({1'b0, conc_i}) - $signed({1'b0, prev_conc_q});
    end else begin
      samp_cnt_q <= samp_cnt_q + 32'h00000001;
    end
  end

  // minute counter for the automatic hold
  // minutes saturate at the longest hold, so the count never wraps
  always_ff @(posedge clk_i) begin
    if (rst_i || st_q != CAS_HOLD) begin
      min_cnt_q  <= 36'h000000000;
      min_done_q <= 6'h00;
    end else if (min_cnt_q == 36'(MINUTE_CYC - 1)) begin
      min_cnt_q  <= 36'h000000000;
      min_done_q <= (min_done_q == CAS_HOLD_MAX) ? min_done_q : min_done_q + 6'h01;
    end else begin
      min_cnt_q <= min_cnt_q + 36'h000000001;
    end
  end

  // sequence state
  // a span can be rejected from manual settling or from the automatic hold
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= CAS_ANALYZE;
    end else begin
      unique case (st_q)
        CAS_ANALYZE: if (start_p) st_q <= CAS_SETTLE;
        CAS_SETTLE: begin
          if (span_end) begin
            st_q <= (sens_i < CAS_SENS_MIN) ? CAS_FAILMSG : CAS_ANALYZE;
          end else if (auto_q && samp_tick && stable) begin
            st_q <= CAS_HOLD;
          end
        end
        CAS_HOLD: begin
          if (span_end) begin
            st_q <= (sens_i < CAS_SENS_MIN) ? CAS_FAILMSG : CAS_ANALYZE;
          end
        end
        CAS_FAILMSG: if (msg_cnt_q == 32'(FAILMSG_CYC - 1)) st_q <= CAS_ANALYZE;
      endcase
    end
  end

  // failure message timer
  always_ff @(posedge clk_i) begin
    if (rst_i || st_q != CAS_FAILMSG) begin
      msg_cnt_q <= 32'h00000000;
    end else begin
      msg_cnt_q <= msg_cnt_q + 32'h00000001;
    end
  end

  // calibration values: accepted span loads, a rejected one leaves the old values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_sens_q <= CAS_SENS_RST;
      span_rdg_q <= '0;
    end else if (span_end && sens_i >= CAS_SENS_MIN) begin
      cal_sens_q <= sens_i;
      span_rdg_q <= span_val_q;
    end
  end

  // fault flag: set by rejection, cleared only by power cycle
  // a later good span leaves it set, so the operator still sees the old failure
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q <= 1'b0;
    end else if (span_end && sens_i < CAS_SENS_MIN) begin
      fault_q <= 1'b1;
    end
  end

  // indications; system relay depends on nothing but the fault
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_alarm_o              <= 1'b0;
      calibration_fault_flag_o <= 1'b0;
      fail_msg_o               <= 1'b0;
      analyze_o                <= 1'b1;
    end else begin
      sys_alarm_o              <= fault_q;
      calibration_fault_flag_o <= fault_q;
      fail_msg_o               <= st_q == CAS_FAILMSG;
      analyze_o                <= st_q == CAS_ANALYZE;
    end
  end

  // bus answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= take;
      dat_o <= 32'h00000000;
      if (take && !we_i) begin
        unique case (adr_i)
          CAS_ADR_ALM1:   dat_o <= {4'h0, alm_cfg_q[0]};
          CAS_ADR_ALM2:   dat_o <= {4'h0, alm_cfg_q[1]};
          CAS_ADR_SPCTL:  dat_o <= {10'h000, hold_min_q, 15'h0000, auto_q};
          CAS_ADR_SPVAL:  dat_o <= {7'h00, span_val_q};
          CAS_ADR_STAT:   dat_o <= {20'h00000, 2'(st_q), fail_msg_o, fault_q,
                                    2'h0, relay_o, 2'h0, alm_q};
          CAS_ADR_SLOPE:  dat_o <= {{(31-CAS_PPM_W){slope_q[CAS_PPM_W]}}, slope_q};
          CAS_ADR_CALSEN: dat_o <= {16'h0000, cal_sens_q};
          default:        dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // checks
  sequence s_reject;
    span_end && sens_i < CAS_SENS_MIN;
  endsequence

  sequence s_toggle_clear;
    clr_evt[1] && !cond[1];
  endsequence

  AST_HIGH_TRIP: assert property (@(posedge clk_i) disable iff (rst_i)
    !alm_cfg_q[0].defeat && alm_cfg_q[0].dir_high && conc_i > alm_cfg_q[0].setpoint
    && $stable(alm_cfg_q[0]) |=> alm_q[0])
    else $error("high alarm did not trip");
  AST_LOW_TRIP: assert property (@(posedge clk_i) disable iff (rst_i)
    !alm_cfg_q[1].defeat && !alm_cfg_q[1].dir_high && conc_i < alm_cfg_q[1].setpoint
    && $stable(alm_cfg_q[1]) |=> alm_q[1])
    else $error("low alarm did not trip");
  AST_FAILSAFE: assert property (@(posedge clk_i) disable iff (rst_i)
    alm_cfg_q[1].deenergize_on_trip_setting && alm_q[1] |=> !relay_o[1])
    else $error("failsafe relay energized in alarm");
  AST_NONFAILSAFE: assert property (@(posedge clk_i) disable iff (rst_i)
    !alm_cfg_q[0].deenergize_on_trip_setting && alm_q[0] |=> relay_o[0])
    else $error("non-failsafe relay not energized in alarm");
  AST_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    alm_q[1] && alm_cfg_q[1].latching && !alm_cfg_q[1].defeat && !clr_evt[1] |=> alm_q[1])
    else $error("latched alarm dropped");
  AST_DEFEAT: assert property (@(posedge clk_i) disable iff (rst_i)
    alm_cfg_q[1].defeat |=> !alm_q[1])
    else $error("defeated alarm active");
  AST_REJECT: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reject |=> fault_q && st_q == CAS_FAILMSG ##1 sys_alarm_o && fail_msg_o)
    else $error("rejected span not flagged");
  AST_FAULT_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_q |=> fault_q)
    else $error("fault flag cleared without power cycle");
  AST_CAL_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reject |=> $stable(cal_sens_q))
    else $error("rejected span changed calibration");
  AST_HOLD_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    hold_min_q >= CAS_HOLD_MIN && hold_min_q <= CAS_HOLD_MAX)
    else $error("hold time out of range");
  AST_MANUAL_ENTER: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == CAS_SETTLE && !auto_q && enter_p && sens_i >= CAS_SENS_MIN
    |=> span_rdg_q == $past(span_val_q) && st_q == CAS_ANALYZE)
    else $error("manual enter did not finish span");
  AST_MANUAL_NOHOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == CAS_SETTLE && !auto_q |=> st_q != CAS_HOLD)
    else $error("manual span entered hold");

  // further checks; the alarm ones use the alarm that each scenario configures that way
  AST_NONLATCH_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
    !alm_cfg_q[0].latching && !cond[0] |=> !alm_q[0])
    else $error("non-latching alarm held after recovery");
  AST_TOGGLE_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    s_toggle_clear |=> !alm_q[1])
    else $error("toggle did not clear latched alarm");
  AST_FAILSAFE_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    alm_cfg_q[1].deenergize_on_trip_setting && !alm_q[1] |=> relay_o[1])
    else $error("failsafe relay off without alarm");
  AST_SYS_FROM_FAULT: assert property (@(posedge clk_i) disable iff (rst_i)
    !fault_q |=> !sys_alarm_o)
    else $error("system alarm without calibration fault");
  AST_HOLD_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == CAS_HOLD && min_done_q < hold_min_q |=> st_q == CAS_HOLD)
    else $error("hold ended before hold time");
  AST_ACCEPT_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    span_end && sens_i >= CAS_SENS_MIN |=> cal_sens_q == $past(sens_i))
    else $error("accepted span not loaded");

endmodule
`default_nettype wire

// ---- test/cas_panel_model.sv ----
// cas_panel_model: operator side of the block, sensor gas level and cell output
// assumes the bench calls its tasks just after a rising edge of clk_i
`timescale 1ns/1ps
`default_nettype none
module cas_panel_model
  import cas_pkg::*;
(
  // clock
  input  wire logic                  clk_i,
  // relay coils seen from the contacts
  input  wire logic [1:0]            relay_i,
  // sensor levels
  output logic      [CAS_PPM_W-1:0]  conc_o,
  output logic      [CAS_SENS_W-1:0] sens_o
);
  logic ramp_q;
  logic [1:0] contact_closed;
  assign contact_closed = relay_i;  // energized coil closes the normally open side

  initial begin
    conc_o = '0;
    sens_o = 16'h0258;
    ramp_q = 1'b0;
  end

  // a drifting reading climbs one ppm a cycle, so slope is known
  always @(posedge clk_i) begin
    if (ramp_q) begin
      conc_o <= conc_o + 18'h00001;
    end
  end

  task automatic set_gas(input logic [CAS_PPM_W-1:0] v, input logic r);
    // stop a running ramp first, so conc_o has a single writer per edge
    if (ramp_q) begin
      ramp_q <= 1'b0;
      @(posedge clk_i);
    end
    conc_o <= v;
    ramp_q <= r;
  endtask

  task automatic set_cell(input logic [CAS_SENS_W-1:0] v);
    sens_o <= v;
  endtask
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// tb_top: self-checking bench for cas_top with short timing parameters
// assumes cas_top acks each wishbone request one cycle after it is taken
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cas_pkg::*;
  localparam int SC = 4;
  localparam int MC = 20;
  localparam int FC = 10;
  logic clk_i, rst_i, cyc, stb, we, ack, flag, fmsg, ana, sys;
  logic [4:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, r;
  logic [1:0] relay;
  logic [CAS_PPM_W-1:0] conc;
  logic [CAS_SENS_W-1:0] sens;
  int fail_count, n_checks, cyc_cnt, n;

  cas_top #(.SAMPLE_CYC(SC), .MINUTE_CYC(MC), .FAILMSG_CYC(FC)) i_cas_top (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .conc_i(conc), .sens_i(sens),
    .relay_o(relay), .sys_alarm_o(sys), .calibration_fault_flag_o(flag),
    .fail_msg_o(fmsg), .analyze_o(ana));
  cas_panel_model i_cas_panel_model (.clk_i(clk_i), .relay_i(relay), .conc_o(conc),
    .sens_o(sens));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one classic cycle; request held until ack is seen, then one idle cycle
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do begin @(posedge clk_i); end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  // bounded wait for analyze mode to come back
  task automatic wait_ana();
    n = 0;
    while (ana !== 1'b1 && n < 2000) begin @(posedge clk_i); n++; end
  endtask

  task automatic t_reset();
    chk("analyze", {31'h0, ana}, 32'h1);
    chk("relays", {30'h0, relay}, 32'h0);
    wb(1'b0, CAS_ADR_ALM1, 32'h0);
    chk("alm1 rst", r, 32'h030003E8);
    wb(1'b0, CAS_ADR_SPCTL, 32'h0);
    chk("hold rst", {26'h0, r[21:16]}, 32'h5);
    wb(1'b0, 5'h1C, 32'h0);
    chk("unmapped", r, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_hold();
    repeat (60) wb(1'b1, CAS_ADR_SPCTL, 32'h00000400);
    wb(1'b0, CAS_ADR_SPCTL, 32'h0);
    chk("hold max", {26'h0, r[21:16]}, 32'h3C);
    repeat (60) wb(1'b1, CAS_ADR_SPCTL, 32'h00000800);
    wb(1'b0, CAS_ADR_SPCTL, 32'h0);
    chk("hold min", {26'h0, r[21:16]}, 32'h1);
    $display("test hold done");
  endtask

  task automatic t_alarms();
    i_cas_panel_model.set_gas(18'h00064, 1'b0);
    wb(1'b1, CAS_ADR_ALM1, 32'h01000064);  // high, setpoint 100
    wb(1'b1, CAS_ADR_ALM2, 32'h0C000032);  // low, failsafe, latching, setpoint 50
    tick(3);
    chk("idle relays", {30'h0, relay}, 32'h2);
    i_cas_panel_model.set_gas(18'h00065, 1'b0);
    tick(3);
    chk("high trip", {30'h0, relay}, 32'h3);
    i_cas_panel_model.set_gas(18'h00064, 1'b0);
    tick(3);
    chk("high clear", {30'h0, relay}, 32'h2);
    i_cas_panel_model.set_gas(18'h00031, 1'b0);
    tick(3);
    chk("low trip", {30'h0, relay}, 32'h0);
    chk("sys quiet", {31'h0, sys}, 32'h0);
    i_cas_panel_model.set_gas(18'h000C8, 1'b0);
    tick(3);
    chk("latched", {30'h0, relay}, 32'h1);
    wb(1'b1, CAS_ADR_ALM2, 32'h0E000032);
    wb(1'b1, CAS_ADR_ALM2, 32'h0C000032);
    tick(3);
    chk("defeat clr", {30'h0, relay}, 32'h3);
    i_cas_panel_model.set_gas(18'h00031, 1'b0);
    tick(3);
    i_cas_panel_model.set_gas(18'h000C8, 1'b0);
    wb(1'b1, CAS_ADR_ALM2, 32'h04000032);
    wb(1'b1, CAS_ADR_ALM2, 32'h0C000032);
    tick(3);
    chk("latch clr", {30'h0, relay}, 32'h3);
    wb(1'b1, CAS_ADR_ALM1, 32'h03000064);  // defeated with gas far above
    tick(3);
    chk("defeated", {30'h0, relay}, 32'h2);
    $display("test alarms done");
  endtask

  // manual span, good cell; the drifting gas also exercises the slope read
  task automatic t_span_manual(input logic [31:0] exp_flag);
    i_cas_panel_model.set_cell(16'h0258);
    wb(1'b1, CAS_ADR_SPVAL, 32'h013EE8A0);
    wb(1'b0, CAS_ADR_SPVAL, 32'h0);
    chk("span val", r, 32'h013EE8A0);
    wb(1'b1, CAS_ADR_SPCTL, 32'h00000100);
    chk("settling", {31'h0, ana}, 32'h0);
    i_cas_panel_model.set_gas(18'h00100, 1'b1);
    tick(4 * SC);
    wb(1'b0, CAS_ADR_SLOPE, 32'h0);
    chk("slope", r, 32'h00000004);
    i_cas_panel_model.set_gas(18'h00100, 1'b0);
    tick(3 * MC);
    chk("no auto end", {31'h0, ana}, 32'h0);
    wb(1'b1, CAS_ADR_SPCTL, 32'h00000200);
    wait_ana();
    chk("enter ends", {31'h0, ana}, 32'h1);
    wb(1'b0, CAS_ADR_CALSEN, 32'h0);
    chk("cal loaded", r, 32'h00000258);
    chk("flag kept", {31'h0, flag}, exp_flag);
    $display("test manual span done");
  endtask

  task automatic t_span_reject();
    int hi;
    hi = 0;
    i_cas_panel_model.set_cell(16'h01F3);
    wb(1'b1, CAS_ADR_SPCTL, 32'h00000101);
    n = 0;
    while (fmsg !== 1'b1 && n < 2000) begin @(posedge clk_i); n++; end
    while (fmsg === 1'b1 && hi < 100) begin @(posedge clk_i); hi++; end
    chk("fail msg len", hi, FC);
    chk("back to analyze", {31'h0, ana}, 32'h1);
    chk("fault flag", {31'h0, flag}, 32'h1);
    chk("sys alarm", {31'h0, sys}, 32'h1);
    wb(1'b0, CAS_ADR_CALSEN, 32'h0);
    chk("cal restored", r, 32'h00000258);
    $display("test reject done");
  endtask

  task automatic t_power_cycle();
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(2);
    chk("flag cleared", {31'h0, flag}, 32'h0);
    chk("sys cleared", {31'h0, sys}, 32'h0);
    $display("test power cycle done");
  endtask

  // guard against a hung handshake or state machine
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    fail_count = 0;
    n_checks = 0;
    cyc_cnt = 0;
    rst_i = 1'b1;
    cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = '0; wdat = '0;
    tick(12);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_hold();
    t_alarms();
    t_span_manual(32'h0);
    t_span_reject();
    t_span_manual(32'h1);
    t_power_cycle();
    end_sim();
  end
endmodule
`default_nettype wire
